// *** rtl/pf_field_route.sv ***
// Two-bit port 0 field decode into function select and pin direction
`timescale 1ns/1ns
module pf_field_route #(
    parameter logic [3:0] DIR_MAP = pf_pkg::PF_DIR_TIMER
) (
    input  wire logic [1:0] sel,
    input  wire logic       gpio_dir,
    output logic [3:0]      fn_onehot,
    output logic            dir
);

    // One-hot function and direction choice
    always_comb begin
        fn_onehot      = 4'h0;
        fn_onehot[sel] = 1'b1;
        if (sel == pf_pkg::PF_FN_GPIO) begin
            dir = gpio_dir;
        end else begin
            dir = DIR_MAP[sel];
        end
    end

endmodule // pf_field_route

// *** rtl/pf_pin_function_select_upper.sv ***
// Upper port 0 and bus/debug pin function select with APB register access
`timescale 1ns/1ns
module pf_pin_function_select_upper (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [31:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    input  wire logic         debug_return_clock,
    input  wire logic         trace_sync_pin,
    input  wire logic [1:0]   boot_mode_pins,
    input  wire logic [8:0]   port_direction,
    output pf_pkg::pf_route_type route
);

    pf_pkg::pf_state_type st_reg;
    pf_pkg::pf_state_type st_next;
    pf_pkg::pf_route_type rt;
    logic                 setup_ph;
    logic                 access_ph;
    logic                 hit_p1;
    logic                 hit_p2;
    logic                 wr_p1;
    logic                 wr_p2;
    logic [31:0]          p1_next;
    logic [31:0]          p2_next;
    logic [31:0]          p2_rst;
    logic [31:0]          rd_data;
    logic [1:0]           bw;
    logic [1:0]           boot_s;
    logic [3:0][3:0]      fn_hot;
    logic [3:0]           fn_dir;

    // APB phase and address decode
    assign setup_ph  = psel & ~penable;
    assign access_ph = psel & penable;
    assign hit_p1    = (paddr == pf_pkg::PF_ADDR_P0_HIGH);
    assign hit_p2    = (paddr == pf_pkg::PF_ADDR_BUS_DBG);
    assign wr_p1     = access_ph & pwrite & hit_p1;
    assign wr_p2     = access_ph & pwrite & hit_p2;

    // Zero wait states; unmapped access answers with an error
    assign pready    = 1'b1;
    assign pslverr   = access_ph & ~(hit_p1 | hit_p2);
    assign prdata    = st_reg.prdata_reg;
    assign route     = st_reg.route_reg;

    // Pin-derived reset image of the second register
    assign boot_s    = st_reg.sync2_reg[pf_pkg::PF_SY_BOOT +: 2];
    always_comb begin
        p2_rst = pf_pkg::PF_P2_RESET;
        p2_rst[pf_pkg::PF_B_DEBUG] = st_reg.sync2_reg[pf_pkg::PF_SY_DBG];
        p2_rst[pf_pkg::PF_B_TRACE] = st_reg.sync2_reg[pf_pkg::PF_SY_TRC];
        p2_rst[pf_pkg::PF_B_WIDTH +: 2] = boot_s;
        if (boot_s == pf_pkg::PF_BW_PORTS) begin
            p2_rst[pf_pkg::PF_B_ADDR +: 3] = pf_pkg::PF_ADDR_NONE;
        end else begin
            p2_rst[pf_pkg::PF_B_ADDR +: 3] = pf_pkg::PF_ADDR_ALL;
        end
    end

    // Register next values: reset, write, or hold
    // writable select registers
    assign p1_next = sys_rst ? pf_pkg::PF_P1_RESET :
                     wr_p1   ? (pwdata & pf_pkg::PF_P1_MASK) : st_reg.p1_reg;
    assign p2_next = sys_rst ? p2_rst :
                     wr_p2   ? (pwdata & pf_pkg::PF_P2_MASK) : st_reg.p2_reg;

    // Read mux, sampled in the setup phase
    // read back
    always_comb begin
        if (hit_p1) begin
            rd_data = st_reg.p1_reg;
        end else if (hit_p2) begin
            rd_data = st_reg.p2_reg;
        end else begin
            rd_data = 32'h0000_0000;
        end
    end

    // Function decode for port 0 pins 27 to 30
    // pins 27 to 30 decode
    for (genvar i = 0; i < pf_pkg::PF_P0_FN_PINS; i++) begin : g_fn
        localparam int LSB = pf_pkg::PF_P0_FIRST_LSB
                           + (pf_pkg::PF_P0_FN_FIRST + i) * pf_pkg::PF_FLD_W;
        pf_field_route #(
            .DIR_MAP (i == pf_pkg::PF_P0_FN_PINS - 1 ? pf_pkg::PF_DIR_P30
                                                      : pf_pkg::PF_DIR_TIMER)
        ) u_fld (
            .sel       (p1_next[LSB +: pf_pkg::PF_FLD_W]),
            .gpio_dir  (port_direction[pf_pkg::PF_P0_FN_FIRST + i]),
            .fn_onehot (fn_hot[i]),
            .dir       (fn_dir[i])
        );
    end

    // Routing derived from the next register values
    assign bw = p2_next[pf_pkg::PF_B_WIDTH +: 2];
    always_comb begin
        rt = '0;
        // GPIO-only pins follow the direction register
        rt.p0_dir = port_direction;
        for (int i = 0; i < pf_pkg::PF_P0_FN_PINS; i++) begin
            rt.p0_dir[pf_pkg::PF_P0_FN_FIRST + i] = fn_dir[i];
            rt.p0_gpio[i] = fn_hot[i][pf_pkg::PF_FN_GPIO];
            rt.p0_ain[i]  = fn_hot[i][pf_pkg::PF_FN_ALT1];
            rt.p0_alt2[i] = fn_hot[i][pf_pkg::PF_FN_ALT2];
            rt.p0_alt3[i] = fn_hot[i][pf_pkg::PF_FN_ALT3];
        end
        rt.debug_en    = p2_next[pf_pkg::PF_B_DEBUG];
        rt.trace_en    = p2_next[pf_pkg::PF_B_TRACE];
        rt.bus_low_en  = (bw != pf_pkg::PF_BW_PORTS);
        rt.bus_mid_en  = (bw == pf_pkg::PF_BW_16) | (bw == pf_pkg::PF_BW_32);
        rt.bus_high_en = (bw == pf_pkg::PF_BW_32);
        if (bw != pf_pkg::PF_BW_32) begin
            rt.ain_hi_en[0] = p2_next[pf_pkg::PF_B_ANALOG_INPUT_4];
            rt.ain_hi_en[1] = p2_next[pf_pkg::PF_B_ANALOG_INPUT_5];
            rt.ain_hi_en[2] = p2_next[pf_pkg::PF_B_ANALOG_INPUT_6];
            rt.ain_hi_en[3] = p2_next[pf_pkg::PF_B_ANALOG_INPUT_7];
            // port 2 pins 29:28 stay ports
            rt.p2_2928_port = 1'b1;
        end
        rt.we_en  = p2_next[pf_pkg::PF_B_WE];
        rt.cs1_en = p2_next[pf_pkg::PF_B_CS1];
        rt.cs2_en = (p2_next[pf_pkg::PF_B_CS2 +: 2] == pf_pkg::PF_CS_ON);
        rt.cs3_en = (p2_next[pf_pkg::PF_B_CS3 +: 2] == pf_pkg::PF_CS_ON);
        // clock output unless A23 in use
        rt.clkout_en = (p2_next[pf_pkg::PF_B_ADDR +: 3] != pf_pkg::PF_ADDR_ALL)
                     & p2_next[pf_pkg::PF_B_CLKOUT];
        rt.addr_en = pf_pkg::pf_addr_mask(p2_next[pf_pkg::PF_B_ADDR +: 3]);
    end

    // Next state assembly; synchronisers run through reset
    always_comb begin
        st_next            = st_reg;
        st_next.sync1_reg  = {boot_mode_pins, trace_sync_pin, debug_return_clock};
        st_next.sync2_reg  = st_reg.sync1_reg;
        st_next.p1_reg     = p1_next;
        st_next.p2_reg     = p2_next;
        st_next.route_reg  = rt;
        if (sys_rst) begin
            st_next.prdata_reg = 32'h0000_0000;
        end else if (setup_ph) begin
            st_next.prdata_reg = rd_data;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        st_reg <= st_next;
    end

    // Checks on bus answer and routing
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_wr_p1;
        psel && penable && pwrite && paddr == pf_pkg::PF_ADDR_P0_HIGH;
    endsequence

    sequence s_wr_p2;
        psel && penable && pwrite && paddr == pf_pkg::PF_ADDR_BUS_DBG;
    endsequence

    sequence s_rd_p2;
        psel && !penable && !pwrite && paddr == pf_pkg::PF_ADDR_BUS_DBG
        ##1 psel && penable;
    endsequence

    bus_unmapped_a: assert property (
        psel && penable && paddr != pf_pkg::PF_ADDR_P0_HIGH
        && paddr != pf_pkg::PF_ADDR_BUS_DBG |-> pslverr)
        else $error("unmapped access without error");

    write_p1_a: assert property (
        s_wr_p1 |=> st_reg.p1_reg == ($past(pwdata) & pf_pkg::PF_P1_MASK))
        else $error("first register write lost");

    read_p2_a: assert property (
        s_rd_p2 |-> prdata == $past(st_reg.p2_reg))
        else $error("second register read wrong");

    gpio_dir_a: assert property (
        st_reg.p1_reg[23:22] == pf_pkg::PF_FN_GPIO
        |-> route.p0_dir[4] == $past(port_direction[4]))
        else $error("pin 27 direction ignores register");

    match_dir_a: assert property (
        s_wr_p1 and (pwdata[23:22] == pf_pkg::PF_FN_ALT3)
        |=> route.p0_dir[4] && route.p0_alt3[0])
        else $error("pin 27 match not driven out");

    eint_route_a: assert property (
        route.p0_alt2[3] == (st_reg.p1_reg[29:28] == pf_pkg::PF_FN_ALT2))
        else $error("pin 30 interrupt routing wrong");

    width_mid_a: assert property (
        s_wr_p2 |=> route.bus_mid_en == ($past(pwdata[5:4]) == pf_pkg::PF_BW_16
                                       || $past(pwdata[5:4]) == pf_pkg::PF_BW_32))
        else $error("middle byte lanes wrong");

    analog_input_6_gate_a: assert property (
        route.ain_hi_en[2] == (st_reg.p2_reg[5:4] != pf_pkg::PF_BW_32
                               && st_reg.p2_reg[pf_pkg::PF_B_ANALOG_INPUT_6]))
        else $error("analog 6 gating wrong");

    clkout_gate_a: assert property (
        st_reg.p2_reg[27:25] == pf_pkg::PF_ADDR_ALL |-> !route.clkout_en)
        else $error("clock output with all address lines");

    cs2_sel_a: assert property (
        route.cs2_en == (st_reg.p2_reg[15:14] == pf_pkg::PF_CS_ON))
        else $error("chip select 2 routing wrong");

    addr_top_a: assert property (
        route.addr_en[21] == (st_reg.p2_reg[27:25] == pf_pkg::PF_ADDR_ALL))
        else $error("address line 23 routing wrong");

    // Reset image follows the pins held through reset
    reset_pins_a: assert property (
        $fell(sys_rst)
        |-> st_reg.p2_reg[pf_pkg::PF_B_DEBUG] == $past(debug_return_clock)
        && st_reg.p2_reg[pf_pkg::PF_B_TRACE] == $past(trace_sync_pin)
        && st_reg.p2_reg[pf_pkg::PF_B_WIDTH +: 2] == $past(boot_mode_pins))
        else $error("reset image ignores boot pins");

    trace_sel_a: assert property (
        s_wr_p2 |=> route.trace_en == $past(pwdata[pf_pkg::PF_B_TRACE]))
        else $error("trace port routing wrong");

    width_ends_a: assert property (
        route.bus_low_en == (st_reg.p2_reg[5:4] != pf_pkg::PF_BW_PORTS)
        && route.bus_high_en == (st_reg.p2_reg[5:4] == pf_pkg::PF_BW_32))
        else $error("outer byte lanes wrong");

    analog_input_4_gate_a: assert property (
        route.ain_hi_en[0] == (st_reg.p2_reg[5:4] != pf_pkg::PF_BW_32
                               && st_reg.p2_reg[pf_pkg::PF_B_ANALOG_INPUT_4]))
        else $error("analog 4 gating wrong");

    p2_ports_a: assert property (
        route.p2_2928_port == (st_reg.p2_reg[5:4] != pf_pkg::PF_BW_32))
        else $error("port 2 pins 29 and 28 routing wrong");

    we_sel_a: assert property (
        s_wr_p2 |=> route.we_en == $past(pwdata[pf_pkg::PF_B_WE]))
        else $error("write enable routing wrong");

    cs1_sel_a: assert property (
        s_wr_p2 |=> route.cs1_en == $past(pwdata[pf_pkg::PF_B_CS1]))
        else $error("chip select 1 routing wrong");

    cs3_sel_a: assert property (
        route.cs3_en == (st_reg.p2_reg[17:16] == pf_pkg::PF_CS_ON))
        else $error("chip select 3 routing wrong");

    p30_input_a: assert property (
        st_reg.p1_reg[29:28] != pf_pkg::PF_FN_GPIO |-> !route.p0_dir[7])
        else $error("pin 30 function not an input");

endmodule // pf_pin_function_select_upper

// *** rtl/pf_pkg.sv ***
// Constants, field layout and types for the upper pin function select block
package pf_pkg;

    // Register byte addresses
    localparam logic [31:0] PF_ADDR_P0_HIGH = 32'hE002_C004;
    localparam logic [31:0] PF_ADDR_BUS_DBG = 32'hE002_C014;

    // Implemented bits; everything else reads as zero
    localparam logic [31:0] PF_P1_MASK      = 32'hFFFF_C000;
    localparam logic [31:0] PF_P2_MASK      = 32'h0E73_E9FC;

    // Reset images (pin-derived fields filled in at reset)
    localparam logic [31:0] PF_P1_RESET     = 32'h1540_0000;
    localparam logic [31:0] PF_P2_RESET     = 32'h0060_00C0;

    // Port 0 upper fields: pins 23 to 31, two bits each from bit 14
    localparam int          PF_P0_FIRST_LSB = 14;
    localparam int          PF_P0_PINS      = 9;
    localparam int          PF_P0_FN_PINS   = 4;
    localparam int          PF_P0_FN_FIRST  = 4;
    localparam int          PF_FLD_W        = 2;

    // Second register bit positions
    localparam int          PF_B_DEBUG      = 2;
    localparam int          PF_B_TRACE      = 3;
    localparam int          PF_B_WIDTH      = 4;
    localparam int          PF_B_ANALOG_INPUT_6       = 6;
    localparam int          PF_B_ANALOG_INPUT_7       = 7;
    localparam int          PF_B_WE         = 8;
    localparam int          PF_B_CS1        = 11;
    localparam int          PF_B_CLKOUT     = 13;
    localparam int          PF_B_CS2        = 14;
    localparam int          PF_B_CS3        = 16;
    localparam int          PF_B_P2_2928    = 20;
    localparam int          PF_B_ANALOG_INPUT_4       = 21;
    localparam int          PF_B_ANALOG_INPUT_5       = 22;
    localparam int          PF_B_ADDR       = 25;

    // Field encodings
    localparam logic [1:0]  PF_FN_GPIO      = 2'h0;
    localparam logic [1:0]  PF_FN_ALT1      = 2'h1;
    localparam logic [1:0]  PF_FN_ALT2      = 2'h2;
    localparam logic [1:0]  PF_FN_ALT3      = 2'h3;
    localparam logic [1:0]  PF_BW_16        = 2'h1;
    localparam logic [1:0]  PF_BW_32        = 2'h2;
    localparam logic [1:0]  PF_BW_PORTS     = 2'h3;
    localparam logic [1:0]  PF_CS_ON        = 2'h1;
    localparam logic [2:0]  PF_ADDR_ALL     = 3'h7;
    localparam logic [2:0]  PF_ADDR_NONE    = 3'h0;

    // Output direction per function code, bit n for code n
    localparam logic [3:0]  PF_DIR_TIMER    = 4'h8;
    localparam logic [3:0]  PF_DIR_P30      = 4'h0;

    // Synchroniser bit positions
    localparam int          PF_SY_DBG       = 0;
    localparam int          PF_SY_TRC       = 1;
    localparam int          PF_SY_BOOT      = 2;

    // Pin routing seen by the pad ring
    typedef struct packed {
        logic [8:0]  p0_dir;
        logic [3:0]  p0_gpio;
        logic [3:0]  p0_ain;
        logic [3:0]  p0_alt2;
        logic [3:0]  p0_alt3;
        logic        debug_en;
        logic        trace_en;
        logic        bus_low_en;
        logic        bus_mid_en;
        logic        bus_high_en;
        logic [3:0]  ain_hi_en;
        logic        p2_2928_port;
        logic        we_en;
        logic        cs1_en;
        logic        cs2_en;
        logic        cs3_en;
        logic        clkout_en;
        logic [21:0] addr_en;
    } pf_route_type;

    // Whole state of the top module
    typedef struct packed {
        logic [3:0]   sync1_reg;
        logic [3:0]   sync2_reg;
        logic [31:0]  p1_reg;
        logic [31:0]  p2_reg;
        logic [31:0]  prdata_reg;
        pf_route_type route_reg;
    } pf_state_type;

    // Address line mask A23..A2 for the line count field
    function automatic logic [21:0] pf_addr_mask(input logic [2:0] n);
        case (n)
            3'h0:    pf_addr_mask = 22'h00_0000;
            3'h1:    pf_addr_mask = 22'h00_0003;
            3'h2:    pf_addr_mask = 22'h00_000F;
            3'h3:    pf_addr_mask = 22'h00_003F;
            3'h4:    pf_addr_mask = 22'h00_03FF;
            3'h5:    pf_addr_mask = 22'h00_3FFF;
            3'h6:    pf_addr_mask = 22'h03_FFFF;
            default: pf_addr_mask = 22'h3F_FFFF;
        endcase
    endfunction

endpackage

// *** verification/tb_top.sv ***
// Self-checking bench for the upper pin function select block
`timescale 1ns/1ns
module tb_top;
    logic                 clk;
    logic                 sys_rst;
    logic                 psel;
    logic                 penable;
    logic                 pwrite;
    logic [31:0]          paddr;
    logic [31:0]          pwdata;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic                 debug_return_clock;
    logic                 trace_sync_pin;
    logic [1:0]           boot_mode_pins;
    logic [8:0]           port_direction;
    pf_pkg::pf_route_type route;
    int                   bad_count = 0;
    int                   samples_checked = 0;
    int                   cycle_count = 0;
    logic [31:0]          p1_model;
    logic [31:0]          p2_model;
    logic [31:0]          rd_data;
    logic                 rd_err;

    pf_pin_function_select_upper uut (
        .clk                (clk),
        .sys_rst            (sys_rst),
        .psel               (psel),
        .penable            (penable),
        .pwrite             (pwrite),
        .paddr              (paddr),
        .pwdata             (pwdata),
        .prdata             (prdata),
        .pready             (pready),
        .pslverr            (pslverr),
        .debug_return_clock (debug_return_clock),
        .trace_sync_pin     (trace_sync_pin),
        .boot_mode_pins     (boot_mode_pins),
        .port_direction     (port_direction),
        .route              (route)
    );

    // Clock, 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Cycle ceiling against hangs
    always @(posedge clk) begin
        cycle_count <= cycle_count + 1;
        if (cycle_count == 20000) begin
            bad_count++;
            finish_test();
        end
    end

    // Counts, verdict and end of run
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Single comparison point
    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string msg);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    // One APB transfer, held until pready at a rising edge
    task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] data);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= data;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd_data = prdata;
        rd_err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Register write that also updates the shadow copies
    task automatic wr_reg(input logic [31:0] addr, input logic [31:0] data);
        apb(1'b1, addr, data);
        check(64'(rd_err), 64'h0, "mapped write error");
        if (addr == pf_pkg::PF_ADDR_P0_HIGH) begin
            p1_model = data & 32'hFFFF_C000;
        end else begin
            p2_model = data & 32'h0E73_E9FC;
        end
    endtask

    // Expected pin routing for given register and direction values
    function automatic pf_pkg::pf_route_type exp_route(input logic [31:0] p1,
            input logic [31:0] p2, input logic [8:0] dir);
        pf_pkg::pf_route_type r;
        logic [1:0]           code;
        logic [1:0]           w;
        int                   acnt [8] = '{0, 2, 4, 6, 10, 14, 18, 22};
        r = '0;
        r.p0_dir = dir;
        for (int i = 0; i < 4; i++) begin
            code = p1[22 + 2 * i +: 2];
            r.p0_gpio[i] = (code == 2'h0);
            r.p0_ain[i]  = (code == 2'h1);
            r.p0_alt2[i] = (code == 2'h2);
            r.p0_alt3[i] = (code == 2'h3);
            if (code != 2'h0) begin
                r.p0_dir[4 + i] = (code == 2'h3) && (i < 3);
            end
        end
        w = p2[5:4];
        r.debug_en     = p2[2];
        r.trace_en     = p2[3];
        r.bus_low_en   = (w != 2'h3);
        r.bus_mid_en   = (w == 2'h1) || (w == 2'h2);
        r.bus_high_en  = (w == 2'h2);
        r.ain_hi_en    = (w == 2'h2) ? 4'h0 : {p2[7], p2[6], p2[22], p2[21]};
        r.p2_2928_port = (w != 2'h2);
        r.we_en        = p2[8];
        r.cs1_en       = p2[11];
        r.cs2_en       = (p2[15:14] == 2'h1);
        r.cs3_en       = (p2[17:16] == 2'h1);
        r.clkout_en    = p2[13] && (p2[27:25] != 3'h7);
        r.addr_en      = 22'((32'h1 << acnt[p2[27:25]]) - 32'h1);
        return r;
    endfunction

    // Read both registers back and compare routing
    task automatic check_all();
        apb(1'b0, pf_pkg::PF_ADDR_P0_HIGH, 32'h0);
        check(64'(rd_data), 64'(p1_model), "port 0 select readback");
        apb(1'b0, pf_pkg::PF_ADDR_BUS_DBG, 32'h0);
        check(64'(rd_data), 64'(p2_model), "bus select readback");
        check(64'(route), 64'(exp_route(p1_model, p2_model, port_direction)),
              "routing");
    endtask

    task automatic do_reset(input logic dbg, input logic trc, input logic [1:0] boot);
        debug_return_clock <= dbg;
        trace_sync_pin     <= trc;
        boot_mode_pins     <= boot;
        sys_rst            <= 1'b1;
        repeat (10) @(posedge clk);
        sys_rst            <= 1'b0;
        p1_model = 32'h1540_0000;
        p2_model = 32'h0060_00C0 | (32'(dbg) << 2) | (32'(trc) << 3) | (32'(boot) << 4);
        p2_model = p2_model | ((boot == 2'h3) ? 32'h0 : 32'h0E00_0000);
    endtask

    // reset values under several pin levels
    task automatic test_reset();
        do_reset(1'b0, 1'b1, 2'h3);
        check_all();
        do_reset(1'b1, 1'b1, 2'h2);
        check_all();
        do_reset(1'b1, 1'b0, 2'h1);
        check_all();
    endtask

    // every code on each of the pin 27 to 30 fields, direction varied
    task automatic test_port0();
        logic [31:0] vals [6] = '{32'h0000_0000, 32'h1540_0000, 32'h2A80_0000,
                                  32'h3FC0_3FFF, 32'h3900_0000, 32'h06C0_0000};
        for (int i = 0; i < 6; i++) begin
            port_direction <= (i % 2 == 0) ? 9'h0A5 : 9'h15A;
            wr_reg(pf_pkg::PF_ADDR_P0_HIGH, vals[i]);
            check_all();
        end
    endtask

    // bus width against analog and port bits
    task automatic test_width();
        for (int w = 0; w < 4; w++) begin
            wr_reg(pf_pkg::PF_ADDR_BUS_DBG, 32'h0060_00CC | (32'(w) << 4));
            check_all();
        end
    endtask

    // strobes, unused bits and address count
    task automatic test_strobes();
        logic [31:0] vals [5] = '{32'h0001_4900, 32'h0000_4100, 32'h0E00_2000,
                                  32'h0C00_2000, 32'h0FE1_69FC};
        for (int i = 0; i < 5; i++) begin
            wr_reg(pf_pkg::PF_ADDR_BUS_DBG, vals[i]);
            check_all();
        end
        for (int n = 0; n < 8; n++) begin
            wr_reg(pf_pkg::PF_ADDR_BUS_DBG, (32'(n) << 25) | 32'h0000_2000);
            check_all();
        end
    endtask

    task automatic test_unmapped();
        logic [31:0] addrs [2] = '{32'hE002_C008, 32'hE002_C000};
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, addrs[i], 32'hFFFF_FFFF);
            check(64'(rd_err), 64'h1, "unmapped write error");
            apb(1'b0, addrs[i], 32'h0);
            check(64'(rd_err), 64'h1, "unmapped read error");
            check(64'(rd_data), 64'h0, "unmapped read data");
            check_all();
        end
    endtask

    // Main sequence
    initial begin
        psel               <= 1'b0;
        penable            <= 1'b0;
        pwrite             <= 1'b0;
        paddr              <= 32'h0;
        pwdata             <= 32'h0;
        port_direction     <= 9'h0;
        test_reset();
        test_port0();
        test_width();
        test_strobes();
        test_unmapped();
        finish_test();
    end
endmodule // tb_top
